// >>> hw/enable_status_regs.vh
// Register map, field positions and timing constants of the enable status block.
`ifndef ENABLE_STATUS_REGS_VH
`define ENABLE_STATUS_REGS_VH
`define ADDR_W 8
`define ENABLE_CONTROL_OFFSET 8'h6c
`define ENABLE_STATUS_OFFSET 8'h9c
`define OWN_ADDRESS_OFFSET 8'h08
`define ENABLE_BIT 0
`define STAT_EN_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_LOST_BIT 2
`define STATUS_RESET 32'h0000_0000
`define OWN_ADDRESS_RESET 7'h55
`define BUS_FREE_NS 5000
`define CLK_PERIOD_NS 10
`endif

// >>> hw/pin_sync.v
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Pin and filtered level.
  input wire pin_in,
  output reg level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // The first stage feeds only the second to keep metastability contained.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s2_reg;
      end
    end
  end
endmodule

// >>> hw/bus_monitor.v
// Start, stop, bit and byte tracker for the sampled two-wire bus.
`timescale 1ns/1ps
module bus_monitor (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Synchronised bus levels.
  input wire scl,
  input wire sda,
  // Decoded events.
  output reg start_pulse,
  output reg stop_pulse,
  output reg byte_done,
  output reg ack_slot_rise,
  output reg [7:0] byte_data,
  output reg bus_busy
);
  reg scl_q;
  reg sda_q;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      byte_done <= 1'b0;
      ack_slot_rise <= 1'b0;
      byte_data <= 8'h00;
      bus_busy <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      byte_done <= 1'b0;
      ack_slot_rise <= 1'b0;
      if (scl && scl_q && sda_q && !sda) begin
        start_pulse <= 1'b1;
        bus_busy <= 1'b1;
        bit_cnt_reg <= 4'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
        stop_pulse <= 1'b1;
        bus_busy <= 1'b0;
        bit_cnt_reg <= 4'h0;
      end else if (scl && !scl_q && bus_busy) begin
        // Bits 0..7 are data, the ninth rising edge is the acknowledge slot.
        if (bit_cnt_reg == 4'h8) begin
          ack_slot_rise <= 1'b1;
          bit_cnt_reg <= 4'h0;
        end else begin
          shift_reg <= {shift_reg[6:0], sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            byte_done <= 1'b1;
            byte_data <= {shift_reg[6:0], sda};
          end
        end
      end
    end
  end
endmodule

// >>> hw/i2c_enable_status.v
// Enable status tracking of a two-wire bus controller, target side.
// Notes on behaviour
// RULE_01: While enabled, both abort flags read 0 and the enabled flag reads 1.
// RULE_02: Abort flags are valid only once the enabled flag reads 0.
// RULE_03: After enable clears, the enabled flag falls only once bus activity allows.
// RULE_04: Lost flag sets when disable aborts a matched receive after a data byte.
// RULE_05: A stop before our NACK with enable cleared sets both abort flags.
// RULE_06: Lost flag stays 0 when disabled outside a receive data phase.
// RULE_07: Busy flag sets when disabled during address or receive data bytes.
// RULE_08: Busy flag also marks forced NACK of a matched address or data byte, or late completion.
// RULE_09: Busy flag stays 0 when disabled while idle or another target is addressed.
// RULE_10: The enabled flag always mirrors the enable state output.
// RULE_11: Enabled flag is 1 while enabled, 0 only when fully inactive.
// RULE_12: Status bits are read-only, reset to 0, reserved bits read 0.
`timescale 1ns/1ps
`include "enable_status_regs.vh"
module i2c_enable_status #(
  parameter BUS_FREE_CYCLES = (`BUS_FREE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire sys_clk,
  input wire resetn,
  // Register port.
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // Two-wire bus pins, enables low while driving.
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe_n,
  output wire sda_out,
  output wire sda_oe_n,
  // Enable state.
  output wire enable_state_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ADDR_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_IGNORE = 3'd5;
  localparam [31:0] FREE_MAX = BUS_FREE_CYCLES;

  reg rst_s1;
  reg rst_s2;
  wire rst_n;
  wire scl_s;
  wire sda_s;
  wire start_p;
  wire stop_p;
  wire byte_p;
  wire ack_p;
  wire [7:0] byte_v;
  wire bus_busy;

  reg controller_enable_control_reg;
  reg [6:0] own_target_address_reg;
  reg enabled_state_flag_reg;
  reg enabled_state_flag_next;
  reg target_receive_lost_flag_reg;
  reg target_receive_lost_flag_next;
  reg target_disabled_busy_flag_reg;
  reg target_disabled_busy_flag_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg data_seen_reg;
  reg data_seen_next;
  reg nack_reg;
  reg nack_next;
  reg ack_drive_reg;
  reg ack_drive_next;
  reg ack_arm_reg;
  reg ack_arm_next;
  reg scl_prev_reg;
  wire scl_fall;
  reg [31:0] free_cnt_reg;
  reg [31:0] free_cnt_next;
  wire addr_match;
  wire disable_pending;

  // Reset is released through two flops so every flop leaves reset together.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  pin_sync u_scl_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(scl_in),
    .level_out(scl_s)
  );

  pin_sync u_sda_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(sda_in),
    .level_out(sda_s)
  );

  bus_monitor u_mon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl(scl_s),
    .sda(sda_s),
    .start_pulse(start_p),
    .stop_pulse(stop_p),
    .byte_done(byte_p),
    .ack_slot_rise(ack_p),
    .byte_data(byte_v),
    .bus_busy(bus_busy)
  );

  assign addr_match = (byte_v[7:1] == own_target_address_reg);
  assign disable_pending = enabled_state_flag_reg && !controller_enable_control_reg;
  assign scl_fall = scl_prev_reg && !scl_s;

  // The device never stretches the clock; it only pulls data low for an acknowledge.
  assign scl_out = 1'b0;
  assign scl_oe_n = 1'b1;
  assign sda_out = 1'b0;
  assign sda_oe_n = !ack_drive_reg;
  assign enable_state_out = enabled_state_flag_reg;

  // Register writes.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      controller_enable_control_reg <= 1'b0;
      own_target_address_reg <= `OWN_ADDRESS_RESET;
    end else if (reg_write) begin
      if (reg_addr == `ENABLE_CONTROL_OFFSET) begin
        controller_enable_control_reg <= reg_wdata[`ENABLE_BIT];
      end
      // The own address is frozen while enabled to avoid matching a moving target.
      if (reg_addr == `OWN_ADDRESS_OFFSET && !enabled_state_flag_reg) begin
        own_target_address_reg <= reg_wdata[6:0];
      end
    end
  end

  // Target tracking and status logic.
  always @* begin
    state_next = state_reg;
    data_seen_next = data_seen_reg;
    nack_next = nack_reg;
    ack_drive_next = ack_drive_reg;
    ack_arm_next = ack_arm_reg;
    free_cnt_next = free_cnt_reg;
    enabled_state_flag_next = enabled_state_flag_reg;
    target_receive_lost_flag_next = target_receive_lost_flag_reg;
    target_disabled_busy_flag_next = target_disabled_busy_flag_reg;
    // Idle time counts only from the disable, so the enabled flag never falls at once.
    if (bus_busy || start_p || controller_enable_control_reg) begin
      free_cnt_next = 32'h0000_0000;
    end else if (free_cnt_reg < FREE_MAX) begin
      free_cnt_next = free_cnt_reg + 32'h0000_0001;
    end
    // Data only changes while the clock is low, so an acknowledge never looks like a start or stop.
    if (scl_fall) begin
      ack_drive_next = ack_arm_reg;
      ack_arm_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_p && enabled_state_flag_reg) begin
          state_next = ST_ADDR;
          data_seen_next = 1'b0;
          nack_next = 1'b0;
        end
      end
      ST_ADDR: begin
        if (byte_p) begin
          if (!addr_match) begin
            state_next = ST_IGNORE;
          end else begin
            // A pending disable forces NACK of the address byte.
            nack_next = disable_pending; // [RULE_08]
            ack_arm_next = !disable_pending;
            state_next = ST_ADDR_ACK;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (ack_p) begin
          if (nack_reg) begin
            state_next = ST_IGNORE;
          end else if (byte_v[0]) begin
            state_next = ST_TX;
          end else begin
            state_next = ST_RX;
          end
        end
      end
      ST_RX: begin
        if (byte_p) begin
          data_seen_next = 1'b1;
          nack_next = disable_pending;
          ack_arm_next = !disable_pending;
        end
        if (ack_p && nack_reg) begin
          state_next = ST_IGNORE;
        end
      end
      ST_TX: begin
        state_next = ST_TX;
      end
      ST_IGNORE: begin
        state_next = ST_IGNORE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (stop_p || (start_p && state_reg != ST_IDLE)) begin
      state_next = start_p ? ST_ADDR : ST_IDLE;
      data_seen_next = 1'b0;
      nack_next = 1'b0;
      ack_arm_next = 1'b0;
    end
    if (disable_pending) begin
      // The flags record what the disable interrupted; idle or foreign traffic leaves them 0.
      if ((state_reg == ST_ADDR || state_reg == ST_ADDR_ACK) && nack_next) begin
        target_disabled_busy_flag_next = 1'b1; // [RULE_07] [RULE_09]
      end
      if (state_reg == ST_RX && (nack_next || stop_p)) begin
        target_disabled_busy_flag_next = 1'b1; // [RULE_07] [RULE_05]
        if (data_seen_reg || byte_p || stop_p) begin
          target_receive_lost_flag_next = 1'b1; // [RULE_04] [RULE_05] [RULE_06]
        end
      end
      // The enabled flag falls only once the bus has been free long enough.
      if (!bus_busy && free_cnt_reg >= FREE_MAX) begin
        enabled_state_flag_next = 1'b0; // [RULE_03] [RULE_11]
      end
    end else if (controller_enable_control_reg) begin
      // Enabling again clears the abort record and forces the enabled view.
      enabled_state_flag_next = 1'b1; // [RULE_01] [RULE_11]
      target_receive_lost_flag_next = 1'b0; // [RULE_01]
      target_disabled_busy_flag_next = 1'b0; // [RULE_01]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      data_seen_reg <= 1'b0;
      nack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      ack_arm_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      free_cnt_reg <= 32'h0000_0000;
      enabled_state_flag_reg <= 1'b0; // [RULE_12]
      target_receive_lost_flag_reg <= 1'b0; // [RULE_12]
      target_disabled_busy_flag_reg <= 1'b0; // [RULE_12]
    end else begin
      state_reg <= state_next;
      data_seen_reg <= data_seen_next;
      nack_reg <= nack_next;
      ack_drive_reg <= ack_drive_next;
      ack_arm_reg <= ack_arm_next;
      scl_prev_reg <= scl_s;
      free_cnt_reg <= free_cnt_next;
      enabled_state_flag_reg <= enabled_state_flag_next;
      target_receive_lost_flag_reg <= target_receive_lost_flag_next;
      target_disabled_busy_flag_reg <= target_disabled_busy_flag_next;
    end
  end

  // Read data appear the cycle after the read strobe; writes to status are ignored.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `STATUS_RESET;
    end else if (reg_read) begin
      case (reg_addr)
        `ENABLE_STATUS_OFFSET: begin
          reg_rdata <= {29'h0000_0000,
            target_receive_lost_flag_reg && !controller_enable_control_reg, // [RULE_01] [RULE_02]
            target_disabled_busy_flag_reg && !controller_enable_control_reg,
            enabled_state_flag_reg}; // [RULE_10] [RULE_12]
        end
        `ENABLE_CONTROL_OFFSET: begin
          reg_rdata <= {31'h0000_0000, controller_enable_control_reg};
        end
        `OWN_ADDRESS_OFFSET: begin
          reg_rdata <= {25'h000_0000, own_target_address_reg};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// >>> test/enable_status_props.sv
// Checker of status reads and enable state timing.
`timescale 1ns/1ps
`include "enable_status_regs.vh"
module enable_status_props #(
  parameter BUS_FREE_CYCLES = 500
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port.
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Bus pins and enable state.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic enable_state_out
);
  logic en_ctl_reg;
  logic [15:0] idle_reg;
  // Idle is counted on the raw pins, which lead the synchronised copy.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_ctl_reg <= 1'b0;
      idle_reg <= 16'h0000;
    end else begin
      if (reg_write && reg_addr == `ENABLE_CONTROL_OFFSET) begin
        en_ctl_reg <= reg_wdata[`ENABLE_BIT];
      end
      idle_reg <= (scl_in && sda_in) ? idle_reg + {15'h0000, ~&idle_reg} : 16'h0000;
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence status_rd;
    reg_read && reg_addr == `ENABLE_STATUS_OFFSET;
  endsequence
  a_flag_mirror: assert property (
    status_rd |=> reg_rdata[0] == $past(enable_state_out)) else $error("bit 0 not mirrored");
  a_enabled_mask: assert property (
    status_rd ##0 (en_ctl_reg && enable_state_out) |=> reg_rdata[2:0] == 3'h1)
    else $error("status not 001 while enabled");
  a_reserved_zero: assert property (
    reg_read |=> reg_rdata[31:3] == 29'h0000_0000) else $error("reserved bits set");
  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 32'h0000_0000) else $error("read data outside read");
  a_no_fast_fall: assert property (
    $fell(en_ctl_reg) && enable_state_out |-> enable_state_out [*2])
    else $error("enabled flag fell at once");
  a_enable_rise: assert property (
    $rose(en_ctl_reg) |-> ##[0:3] enable_state_out) else $error("enabled flag late");
  a_fall_when_idle: assert property (
    $fell(enable_state_out) |-> !en_ctl_reg && idle_reg >= BUS_FREE_CYCLES / 2)
    else $error("enabled flag fell while busy");
  a_ack_enabled: assert property (
    !sda_oe_n |-> enable_state_out) else $error("data driven while inactive");
endmodule

// >>> test/remote_master.sv
// Behavioural remote bus master on open-drain clock and data.
`timescale 1ns/1ps
module remote_master (
  // Bus levels.
  input wire sda_line,
  output reg scl_drv = 1'b1,
  output reg sda_drv = 1'b1
);
  // Sampled data level of the last bit, the acknowledge after a byte.
  reg ack = 1'b1;
  task start;
    begin
      sda_drv = 1'b0;
      #62.5;
    end
  endtask
  task bit_out(input logic b);
    begin
      scl_drv = 1'b0;
      #31.25 sda_drv = b;
      #31.25 scl_drv = 1'b1;
      #31.25 ack = sda_line;
      #31.25;
    end
  endtask
  // The data line is released for the acknowledge, so the pull-up shows.
  task send(input logic [7:0] data);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_out(data[i]);
      end
      bit_out(1'b1);
    end
  endtask
  task stop;
    begin
      scl_drv = 1'b0;
      #31.25 sda_drv = 1'b0;
      #31.25 scl_drv = 1'b1;
      #31.25 sda_drv = 1'b1;
      #31.25;
    end
  endtask
endmodule

// >>> test/tb.sv
// Bench of the enable status block with a remote bus master.
`timescale 1ns/1ps
`include "enable_status_regs.vh"
module tb;
  localparam FREE = 20;
  localparam [7:0] ST = `ENABLE_STATUS_OFFSET;
  localparam [7:0] EN = `ENABLE_CONTROL_OFFSET;
  typedef struct {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e;} row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  wire [31:0] reg_rdata;
  wire scl_out, scl_oe_n, sda_out, sda_oe_n, enable_state_out, scl_drv, sda_drv;
  wire scl_in = scl_drv & (scl_oe_n | scl_out);
  wire sda_in = sda_drv & (sda_oe_n | sda_out);
  integer errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer i;
  row_t rows [0:6];
  always #5 sys_clk = ~sys_clk;
  i2c_enable_status #(.BUS_FREE_CYCLES(FREE)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .enable_state_out(enable_state_out));
  remote_master m (.sda_line(sda_in), .scl_drv(scl_drv), .sda_drv(sda_drv));
  task results;
    begin
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  // Set abort flags are only expected once the enabled flag has dropped.
  task wait_off;
    integer n;
    begin
      n = 0;
      while (enable_state_out !== 1'b0 && n < 400) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk(enable_state_out, 1'b0);
    end
  endtask
  task go(input logic [7:0] ab, input logic late, input logic nack, input logic [31:0] e);
    begin
      wr(EN, 32'h0000_0001);
      m.start;
      if (!late) wr(EN, 32'h0000_0000);
      m.send(ab);
      chk(m.ack, nack);
      m.send(8'h11);
      if (late) wr(EN, 32'h0000_0000);
      m.stop;
      wait_off;
      rd(ST, e);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      results;
    end
  end
  initial begin
    rows[0] = '{ST, 32'h0000_0000, 1'b0, 32'h0000_0000};
    rows[1] = '{ST, 32'hffff_ffff, 1'b1, 32'h0000_0000};
    rows[2] = '{ST, 32'h0000_0000, 1'b0, 32'h0000_0000};
    rows[3] = '{8'h40, 32'h0000_0000, 1'b0, 32'h0000_0000};
    rows[4] = '{EN, 32'h0000_0001, 1'b1, 32'h0000_0000};
    rows[5] = '{ST, 32'h0000_0006, 1'b1, 32'h0000_0000};
    rows[6] = '{ST, 32'h0000_0000, 1'b0, 32'h0000_0001};
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 7; i = i + 1) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    end
    m.start;
    m.send(8'haa);
    chk(m.ack, 1'b0);
    rd(ST, 32'h0000_0001);
    fork
      m.send(8'h22);
      begin
        #300;
        wr(EN, 32'h0000_0000);
      end
    join
    chk(enable_state_out, 1'b1);
    m.stop;
    wait_off;
    rd(ST, 32'h0000_0006);
    go(8'haa, 1'b1, 1'b0, 32'h0000_0006);
    go(8'hab, 1'b0, 1'b1, 32'h0000_0002);
    go(8'h44, 1'b0, 1'b1, 32'h0000_0000);
    wr(EN, 32'h0000_0001);
    wr(EN, 32'h0000_0000);
    wait_off;
    rd(ST, 32'h0000_0000);
    wr(EN, 32'h0000_0001);
    rd(ST, 32'h0000_0001);
    results;
  end
endmodule
bind i2c_enable_status enable_status_props #(.BUS_FREE_CYCLES(BUS_FREE_CYCLES)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .enable_state_out(enable_state_out));
